// *** hdl/mtp_timer.sv ***
`timescale 1ns/1ps
`include "mtp_consts.svh"

module mtp_timer (
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    input  wire mtp_pkg::mtp_bus_s bus_in,
    output logic [15:0]           rdata_out,
    output logic                  irq_out,
    input  wire logic             bidir_timer_pin_in,
    output logic                  bidir_timer_pin_out,
    output logic                  bidir_timer_pin_oe_out,
    input  wire logic             input_only_timer_pin_in
);

    function automatic mtp_pkg::mtp_mode_e mtp_decode(input logic [2:0] m);
        mtp_pkg::mtp_mode_e r;
        r = mtp_pkg::MTP_MD_CAP;
        case (m)
            3'h0, 3'h1: r = mtp_pkg::MTP_MD_EVT;
            3'h4, 3'h5: r = mtp_pkg::MTP_MD_PWM;
            default:    r = mtp_pkg::MTP_MD_CAP;
        endcase
        return r;
    endfunction

    mtp_pkg::mtp_state_s st_reg;
    mtp_pkg::mtp_state_s st_next;
    mtp_pkg::mtp_mode_e  md;
    logic                wr_ctrl;
    logic                wr_status;
    logic                wr_enable;
    logic                wr_first;
    logic                wr_second;
    logic                wr_count;
    logic                a_rise;
    logic                a_fall;
    logic                b_rise;
    logic                b_fall;
    logic                cap_a_edge;
    logic                cap_b_edge;
    logic                tick;
    logic                uf;
    logic [1:0]          pnd_set;
    logic [1:0]          pnd_clr;

    assign md        = mtp_decode(st_reg.mode);
    assign wr_ctrl   = bus_in.wr && (bus_in.addr == `MTP_ADDR_CTRL);
    assign wr_status = bus_in.wr && (bus_in.addr == `MTP_ADDR_STATUS);
    assign wr_enable = bus_in.wr && (bus_in.addr == `MTP_ADDR_ENABLE);
    assign wr_first  = bus_in.wr && (bus_in.addr == `MTP_ADDR_FIRST);
    assign wr_second = bus_in.wr && (bus_in.addr == `MTP_ADDR_SECOND);
    assign wr_count  = bus_in.wr && (bus_in.addr == `MTP_ADDR_COUNT);

    assign a_rise = bidir_timer_pin_in && !st_reg.a_prev;
    assign a_fall = !bidir_timer_pin_in && st_reg.a_prev;
    assign b_rise = input_only_timer_pin_in && !st_reg.b_prev;
    assign b_fall = !input_only_timer_pin_in && st_reg.b_prev;

    // R14 capture edge select
    assign cap_a_edge = (st_reg.mode == `MTP_MODE_CAP_RR ||
                         st_reg.mode == `MTP_MODE_CAP_RF) ? a_rise : a_fall;
    assign cap_b_edge = (st_reg.mode == `MTP_MODE_CAP_RR) ? b_rise : b_fall;

    // R16 R8 R11 count source
    always_comb
    begin
        case (md)
            mtp_pkg::MTP_MD_PWM: tick = st_reg.run;
            mtp_pkg::MTP_MD_EVT: tick = st_reg.run && a_rise;
            mtp_pkg::MTP_MD_CAP: tick = 1'b1;
            default:             tick = 1'b0;
        endcase
    end

    assign uf = tick && (st_reg.cnt == `MTP_CNT_ZERO);

    always_comb
    begin
        st_next        = st_reg;
        pnd_set        = 2'h0;
        pnd_clr        = 2'h0;
        st_next.a_prev = bidir_timer_pin_in;
        st_next.b_prev = input_only_timer_pin_in;

        if (wr_ctrl)
        begin
            st_next.mode = bus_in.wdata[`MTP_CTRL_MODE_MSB:`MTP_CTRL_MODE_LSB];
            st_next.run  = bus_in.wdata[`MTP_CTRL_RUN_BIT];
        end
        if (wr_enable)
        begin
            st_next.en = bus_in.wdata[1:0];
        end
        if (wr_first)
        begin
            st_next.first_reload_capture_reg = bus_in.wdata;
        end
        if (wr_second)
        begin
            st_next.second_reload_capture_reg = bus_in.wdata;
        end
        if (wr_status)
        begin
            pnd_clr = bus_in.wdata[1:0];
        end

        // R1 R2 counter runs from whatever software loaded
        if (tick && !uf)
        begin
            st_next.cnt = st_reg.cnt - `MTP_CNT_ONE;
        end

        case (md)
            mtp_pkg::MTP_MD_PWM:
            begin
                // R3 R5 alternate reloads and their pending flags
                if (!st_reg.run)
                begin
                    st_next.alt = 1'b0;
                end
                else if (uf && !st_reg.alt)
                begin
                    st_next.cnt = st_reg.first_reload_capture_reg;
                    st_next.alt = 1'b1;
                    pnd_set[`MTP_PND_FIRST_BIT] = 1'b1;
                end
                else if (uf)
                begin
                    st_next.cnt = st_reg.second_reload_capture_reg;
                    st_next.alt = 1'b0;
                    pnd_set[`MTP_PND_SECOND_BIT] = 1'b1;
                end
                // R4 pin toggles only in the toggle variant
                if (uf && st_reg.mode == `MTP_MODE_PWM_TOGGLE)
                begin
                    st_next.pin_lvl = !st_reg.pin_lvl;
                end
            end
            mtp_pkg::MTP_MD_EVT:
            begin
                // R7 R17 underflow reloads first register
                if (uf)
                begin
                    st_next.cnt = st_reg.first_reload_capture_reg;
                    pnd_set[`MTP_PND_FIRST_BIT] = 1'b1;
                end
                // R9 independent edge interrupt
                pnd_set[`MTP_PND_SECOND_BIT] = b_rise;
            end
            mtp_pkg::MTP_MD_CAP:
            begin
                // R13 underflow wraps and raises the run bit
                if (uf)
                begin
                    st_next.cnt = `MTP_CNT_WRAP;
                    st_next.run = 1'b1;
                end
                // R11 R12 captures beat a same-cycle software write
                if (cap_a_edge)
                begin
                    st_next.first_reload_capture_reg = st_reg.cnt;
                end
                if (cap_b_edge)
                begin
                    st_next.second_reload_capture_reg = st_reg.cnt;
                end
                pnd_set = {cap_b_edge, cap_a_edge};
            end
            default:
            begin
                st_next.alt = st_reg.alt;
            end
        endcase

        // Software load of the counter wins over counting.
        if (wr_count)
        begin
            st_next.cnt = bus_in.wdata;
        end

        // R10 pin driven only in PWM
        st_next.pin_oe = (mtp_decode(st_next.mode) == mtp_pkg::MTP_MD_PWM);

        // R15 set wins over a same-cycle clear
        st_next.pnd = (st_reg.pnd & ~pnd_clr) | pnd_set;

        // R6 R13 level interrupt from flags and enables
        st_next.irq = |(st_next.pnd & st_next.en) ||
                      (mtp_decode(st_next.mode) == mtp_pkg::MTP_MD_CAP &&
                       st_next.run && st_next.en[`MTP_PND_FIRST_BIT]);

        st_next.rdata = `MTP_RD_ZERO;
        if (bus_in.rd)
        begin
            case (bus_in.addr)
                `MTP_ADDR_CTRL:   st_next.rdata = {12'h000, st_reg.mode,
                                                   st_reg.run};
                `MTP_ADDR_STATUS: st_next.rdata = {14'h0000, st_reg.pnd};
                `MTP_ADDR_ENABLE: st_next.rdata = {14'h0000, st_reg.en};
                `MTP_ADDR_FIRST:  st_next.rdata =
                                      st_reg.first_reload_capture_reg;
                `MTP_ADDR_SECOND: st_next.rdata =
                                      st_reg.second_reload_capture_reg;
                `MTP_ADDR_COUNT:  st_next.rdata = st_reg.cnt;
                default:          st_next.rdata = `MTP_RD_ZERO;
            endcase
        end
    end

    // Counter and reload values are cleared only to keep simulation clean.
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_out              = st_reg.rdata;
    assign irq_out                = st_reg.irq;
    assign bidir_timer_pin_out    = st_reg.pin_lvl;
    assign bidir_timer_pin_oe_out = st_reg.pin_oe;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    chk_pwm_reload_first: assert property ( // R3
        (md == mtp_pkg::MTP_MD_PWM && uf && !st_reg.alt && !wr_count)
        |=> (st_reg.cnt == $past(st_reg.first_reload_capture_reg)
             && st_reg.pnd[0]))
        else $error("PWM first underflow did not reload first register");

    chk_pwm_alternate: assert property ( // R5
        (md == mtp_pkg::MTP_MD_PWM && uf && st_reg.alt && !wr_count)
        |=> (st_reg.cnt == $past(st_reg.second_reload_capture_reg)
             && st_reg.pnd[1] && !st_reg.alt))
        else $error("PWM second underflow did not reload second register");

    chk_pwm_pin_toggle: assert property ( // R4
        (md == mtp_pkg::MTP_MD_PWM && uf && !wr_ctrl &&
         st_reg.mode == `MTP_MODE_PWM_TOGGLE)
        |=> (bidir_timer_pin_out != $past(bidir_timer_pin_out))
            && bidir_timer_pin_oe_out)
        else $error("PWM toggle mode pin did not toggle");

    chk_irq_follows: assert property ( // R6
        (st_reg.pnd[0] && st_reg.en[0]) |-> irq_out)
        else $error("Interrupt low while pending and enabled");

    chk_evt_no_drive: assert property ( // R10
        (md == mtp_pkg::MTP_MD_EVT && !wr_ctrl) |=> !bidir_timer_pin_oe_out)
        else $error("Pin driven in event counter mode");

    chk_evt_b_edge: assert property ( // R9
        (md == mtp_pkg::MTP_MD_EVT && b_rise) |=> st_reg.pnd[1])
        else $error("Input pin rising edge not latched");

    chk_evt_reload: assert property ( // R7
        (md == mtp_pkg::MTP_MD_EVT && uf && !wr_count)
        |=> (st_reg.cnt == $past(st_reg.first_reload_capture_reg)
             && st_reg.pnd[0]))
        else $error("Event underflow did not reload or flag");

    chk_cap_first: assert property ( // R11
        (md == mtp_pkg::MTP_MD_CAP && cap_a_edge)
        |=> (st_reg.first_reload_capture_reg == $past(st_reg.cnt)
             && st_reg.pnd[0]))
        else $error("Capture on bidirectional pin lost");

    chk_cap_uf_run: assert property ( // R13
        (md == mtp_pkg::MTP_MD_CAP && uf && !wr_count)
        |=> (st_reg.run && st_reg.cnt == `MTP_CNT_WRAP))
        else $error("Capture underflow did not set run bit");

    chk_stop_holds: assert property ( // R16
        (md != mtp_pkg::MTP_MD_CAP && !st_reg.run && !wr_count)
        |=> $stable(st_reg.cnt))
        else $error("Stopped counter moved");

    chk_pnd_sticky: assert property ( // R15
        (st_reg.pnd[0] && !(wr_status && bus_in.wdata[0]))
        |=> st_reg.pnd[0])
        else $error("Pending flag cleared without software");

    chk_pwm_no_toggle: assert property ( // R4
        (md == mtp_pkg::MTP_MD_PWM &&
         st_reg.mode != `MTP_MODE_PWM_TOGGLE) |=> $stable(bidir_timer_pin_out))
        else $error("PWM pin moved in the mode without toggle");

    chk_pwm_drives: assert property ( // R4
        (md == mtp_pkg::MTP_MD_PWM && !wr_ctrl) |=> bidir_timer_pin_oe_out)
        else $error("Pin not driven in PWM mode");

    chk_pwm_count: assert property ( // R3
        (md == mtp_pkg::MTP_MD_PWM && st_reg.run && !uf && !wr_count)
        |=> (st_reg.cnt == $past(st_reg.cnt) - `MTP_CNT_ONE))
        else $error("PWM counter did not step down");

    chk_irq_second: assert property ( // R6
        (st_reg.pnd[1] && st_reg.en[1]) |-> irq_out)
        else $error("Interrupt low while second flag pending and enabled");

    // A spurious request is as harmful as a lost one, so both are checked.
    chk_irq_cause: assert property ( // R6
        irq_out |-> (((st_reg.pnd & st_reg.en) != 2'h0) ||
                     (md == mtp_pkg::MTP_MD_CAP && st_reg.run &&
                      st_reg.en[0])))
        else $error("Interrupt high with no enabled cause");

    chk_evt_step: assert property ( // R7
        (md == mtp_pkg::MTP_MD_EVT && st_reg.run && a_rise && !uf
         && !wr_count)
        |=> (st_reg.cnt == $past(st_reg.cnt) - `MTP_CNT_ONE))
        else $error("Event counter missed a rising pin edge");

    chk_evt_edge_only: assert property ( // R8
        (md == mtp_pkg::MTP_MD_EVT && !a_rise && !wr_count)
        |=> $stable(st_reg.cnt))
        else $error("Event counter moved without a rising pin edge");

    chk_cap_runs: assert property ( // R11
        (md == mtp_pkg::MTP_MD_CAP && !uf && !wr_count)
        |=> (st_reg.cnt == $past(st_reg.cnt) - `MTP_CNT_ONE))
        else $error("Capture mode counter did not advance");

    chk_cap_second: assert property ( // R12
        (md == mtp_pkg::MTP_MD_CAP && cap_b_edge)
        |=> (st_reg.second_reload_capture_reg == $past(st_reg.cnt)
             && st_reg.pnd[1]))
        else $error("Capture on input pin lost");

    cov_pwm_both: cover property (
        (md == mtp_pkg::MTP_MD_PWM && uf && !st_reg.alt) ##[1:1000]
        (md == mtp_pkg::MTP_MD_PWM && uf && st_reg.alt));
    cov_evt_uf: cover property (md == mtp_pkg::MTP_MD_EVT && uf);
    cov_cap_both: cover property (
        md == mtp_pkg::MTP_MD_CAP && cap_a_edge && cap_b_edge);
    cov_irq: cover property ($rose(irq_out));

endmodule

// *** hdl/mtp_consts.svh ***
// Operation
// R1: One 16-bit down counter plus two 16-bit reload or capture registers.
// R2: Counter and both registers hold no meaningful value until software writes.
// R3: PWM counts every cycle; underflows reload first, second, first, alternately.
// R4: Mode 101 is PWM with pin toggle; mode 100 is PWM without toggle.
// R5: PWM reload from first sets first pending; from second sets second.
// R6: Interrupt requested while any pending flag and its enable are both set.
// R7: Event mode counts pin edges; each underflow sets the first pending flag.
// R8: Modes 000 and 001 select event counting on the rising pin edge.
// R9: Event mode: rising edge on input-only pin sets second pending flag.
// R10: Event mode never drives the bidirectional pin.
// R11: Capture mode counts freely; pin edges copy counter into matching register.
// R12: Capture on bidirectional or input pin sets first or second pending flag.
// R13: Capture mode underflow sets the run bit, which requests interrupt A.
// R14: Edges: 010 both rising; 110 rise and fall; 011 and 111 both falling.
// R15: Software clears pending flags itself; hardware never clears them.
// R16: In PWM and event modes the run bit starts and stops the counter.
// R17: Event mode reloads from the first register at every underflow.
`ifndef MTP_CONSTS_SVH
`define MTP_CONSTS_SVH

`define MTP_ADDR_CTRL    3'h0
`define MTP_ADDR_STATUS  3'h1
`define MTP_ADDR_ENABLE  3'h2
`define MTP_ADDR_FIRST   3'h3
`define MTP_ADDR_SECOND  3'h4
`define MTP_ADDR_COUNT   3'h5

`define MTP_CTRL_RUN_BIT   0
`define MTP_CTRL_MODE_LSB  1
`define MTP_CTRL_MODE_MSB  3
`define MTP_PND_FIRST_BIT  0
`define MTP_PND_SECOND_BIT 1

`define MTP_MODE_PWM_TOGGLE 3'h5
`define MTP_MODE_CAP_RR     3'h2
`define MTP_MODE_CAP_RF     3'h6

`define MTP_CNT_ONE   16'h0001
`define MTP_CNT_ZERO  16'h0000
`define MTP_CNT_WRAP  16'hFFFF
`define MTP_RD_ZERO   16'h0000

`endif

// *** hdl/mtp_pkg.sv ***
package mtp_pkg;

    typedef enum logic [2:0] {
        MTP_MD_PWM = 3'b001,
        MTP_MD_EVT = 3'b010,
        MTP_MD_CAP = 3'b100
    } mtp_mode_e;

    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mtp_bus_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] first_reload_capture_reg;
        logic [15:0] second_reload_capture_reg;
        logic [2:0]  mode;
        logic        run;
        logic [1:0]  pnd;
        logic [1:0]  en;
        logic        alt;
        logic        pin_lvl;
        logic        pin_oe;
        logic        a_prev;
        logic        b_prev;
        logic [15:0] rdata;
        logic        irq;
    } mtp_state_s;

endpackage

// *** test/mtp_pin_model.sv ***
`timescale 1ns/1ps

module mtp_pin_model (
    input  wire logic drv_in,
    input  wire logic oe_in,
    input  wire logic ext_a_in,
    input  wire logic ext_b_in,
    output logic      bidir_out,
    output logic      input_only_out
);
    // shared pin level.
    // The outside world drives the shared pin only while the timer lets go.
    // Contention is not modelled, so a bench fault there goes unseen.
    assign bidir_out      = oe_in ? drv_in : ext_a_in;
    assign input_only_out = ext_b_in;
endmodule

// *** test/test_multimode_timer_pwm_capture.sv ***
`timescale 1ns/1ps
`include "mtp_consts.svh"

module test_multimode_timer_pwm_capture;
    logic              core_clk_in = 1'b0;
    logic              rst_b_in    = 1'b0;
    mtp_pkg::mtp_bus_s bus         = '0;
    logic [15:0]       rdata;
    logic              irq;
    logic              pin_drv;
    logic              pin_oe;
    logic              a_pin;
    logic              b_pin;
    logic              ext_a       = 1'b0;
    logic              ext_b       = 1'b0;
    logic [15:0]       rd_val;
    logic [15:0]       cap_a;
    logic [2:0]        cap_mode [4] = '{3'h2, 3'h6, 3'h3, 3'h7};
    logic              a_rise [4]   = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic              b_rise [4]   = '{1'b1, 1'b0, 1'b0, 1'b0};
    int                n_fail       = 0;
    int                tests_run    = 0;
    int                t0;
    int                t1;
    int                t2;

    always #5 core_clk_in = ~core_clk_in;

    mtp_timer dut_u (
        .core_clk_in             (core_clk_in),
        .rst_b_in                (rst_b_in),
        .bus_in                  (bus),
        .rdata_out               (rdata),
        .irq_out                 (irq),
        .bidir_timer_pin_in      (a_pin),
        .bidir_timer_pin_out     (pin_drv),
        .bidir_timer_pin_oe_out  (pin_oe),
        .input_only_timer_pin_in (b_pin)
    );

    mtp_pin_model pins_u (
        .drv_in         (pin_drv),
        .oe_in          (pin_oe),
        .ext_a_in       (ext_a),
        .ext_b_in       (ext_b),
        .bidir_out      (a_pin),
        .input_only_out (b_pin)
    );

    task automatic test_done;
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge core_clk_in);
        bus.wr    <= 1'b0;
    endtask

    // Read data only stand in the cycle after the strobe, so sample there.
    task automatic rd(input logic [2:0] a);
        @(posedge core_clk_in);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge core_clk_in);
        bus.rd   <= 1'b0;
        @(negedge core_clk_in);
        rd_val = rdata;
    endtask

    // Pin edges are spaced three cycles apart at the least.
    task automatic pin(input logic a, input logic b);
        @(posedge core_clk_in);
        ext_a <= a;
        ext_b <= b;
        cycles(2);
    endtask

    task automatic wait_tog(output int n);
        logic last;
        last = pin_drv;
        n = 0;
        while (n < 30 && pin_drv === last)
        begin
            @(negedge core_clk_in);
            n++;
        end
    endtask

    initial
    begin
        cycles(16);
        rst_b_in <= 1'b1;
        cycles(2);
        chk("irq_reset", {15'h0000, irq}, 16'h0000);
        chk("oe_reset", {15'h0000, pin_oe}, 16'h0000);
        chk("rdata_idle", rdata, 16'h0000);
        rd(3'h6);
        chk("unmapped", rd_val, 16'h0000);
        wr(`MTP_ADDR_FIRST, 16'h0003);
        wr(`MTP_ADDR_SECOND, 16'h0005);
        wr(`MTP_ADDR_COUNT, 16'h0000);
        wr(`MTP_ADDR_ENABLE, 16'h0001);
        wr(`MTP_ADDR_CTRL, 16'h000B);
        wait_tog(t0);
        wait_tog(t1);
        wait_tog(t2);
        chk("pwm_half_a", 16'(t1), 16'h0004);
        chk("pwm_half_b", 16'(t2), 16'h0006);
        wr(`MTP_ADDR_CTRL, 16'h000A);
        rd(`MTP_ADDR_STATUS);
        chk("pwm_pend", rd_val, 16'h0003);
        chk("irq_a", {15'h0000, irq}, 16'h0001);
        // Software clears the first flag only; the second must survive.
        wr(`MTP_ADDR_STATUS, 16'h0001);
        rd(`MTP_ADDR_STATUS);
        chk("w1c", rd_val, 16'h0002);
        chk("irq_masked", {15'h0000, irq}, 16'h0000);
        wr(`MTP_ADDR_ENABLE, 16'h0002);
        cycles(1);
        chk("irq_b", {15'h0000, irq}, 16'h0001);
        wr(`MTP_ADDR_CTRL, 16'h0009);
        wait_tog(t0);
        chk("no_toggle", 16'(t0), 16'h001E);
        for (int m = 0; m < 2; m++)
        begin
            wr(`MTP_ADDR_CTRL, 16'(2 * m + 1));
            wr(`MTP_ADDR_FIRST, 16'h0002);
            wr(`MTP_ADDR_COUNT, 16'h0001);
            wr(`MTP_ADDR_STATUS, 16'h0003);
            chk("evt_oe", {15'h0000, pin_oe}, 16'h0000);
            pin(1'b1, 1'b0);
            pin(1'b0, 1'b0);
            pin(1'b1, 1'b0);
            pin(1'b0, 1'b0);
            rd(`MTP_ADDR_COUNT);
            chk("evt_reload", rd_val, 16'h0002);
            rd(`MTP_ADDR_STATUS);
            chk("evt_uf", rd_val, 16'h0001);
            pin(1'b0, 1'b1);
            rd(`MTP_ADDR_STATUS);
            chk("evt_b", rd_val, 16'h0003);
            wr(`MTP_ADDR_CTRL, 16'(2 * m));
            pin(1'b1, 1'b0);
            pin(1'b0, 1'b0);
            rd(`MTP_ADDR_COUNT);
            chk("evt_hold", rd_val, 16'h0002);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(`MTP_ADDR_CTRL, {12'h000, cap_mode[i], 1'b0});
            pin(!a_rise[i], !b_rise[i]);
            wr(`MTP_ADDR_STATUS, 16'h0003);
            @(posedge core_clk_in);
            ext_a <= a_rise[i];
            cycles(7);
            ext_b <= b_rise[i];
            cycles(3);
            rd(`MTP_ADDR_STATUS);
            chk("cap_pend", rd_val, 16'h0003);
            rd(`MTP_ADDR_FIRST);
            cap_a = rd_val;
            rd(`MTP_ADDR_SECOND);
            chk("cap_span", cap_a - rd_val, 16'h0007);
        end
        wr(`MTP_ADDR_STATUS, 16'h0003);
        wr(`MTP_ADDR_ENABLE, 16'h0001);
        wr(`MTP_ADDR_COUNT, 16'h0003);
        cycles(8);
        rd(`MTP_ADDR_CTRL);
        chk("cap_uf", rd_val, 16'h000F);
        chk("cap_uf_irq", {15'h0000, irq}, 16'h0001);
        wr(`MTP_ADDR_CTRL, 16'h000E);
        cycles(1);
        chk("cap_uf_clr", {15'h0000, irq}, 16'h0000);
        test_done();
    end

    // The sequence needs a few hundred cycles; this is far beyond that.
    initial
    begin
        #300000;
        n_fail++;
        test_done();
    end
endmodule
